/* src/clk_src_pkg.sv */
// Constants shared by the clock source control block
package clk_src_pkg;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          VDET_DELAY_NS   = 100000;
    localparam int          VDET_DELAY_CYC  = (VDET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ADDR_W          = 8;
    localparam int          IDX_W           = 6;
    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_CLK_MODE    = 6'h06;
    localparam logic [5:0]  IDX_WPROT       = 6'h0A;
    localparam logic [5:0]  IDX_FAST_CTRL   = 6'h23;
    localparam logic [5:0]  IDX_TRIM_A      = 6'h24;
    localparam logic [5:0]  IDX_PRESC       = 6'h28;
    localparam logic [5:0]  IDX_F36_A       = 6'h29;
    localparam logic [5:0]  IDX_F36_B       = 6'h2A;
    localparam logic [5:0]  IDX_F32_A       = 6'h2B;
    localparam logic [5:0]  IDX_F32_B       = 6'h2C;
    localparam logic [5:0]  IDX_TRIM_B      = 6'h2F;
    localparam logic [5:0]  IDX_VDET        = 6'h34;
    // Field positions
    localparam int          PRESC_BIT       = 7;
    localparam int          FAST_ON_BIT     = 0;
    localparam int          UNLOCK_CLK_BIT  = 0;
    localparam int          UNLOCK_VOLT_BIT = 3;
    localparam int          LOWPWR_BIT      = 0;
    localparam int          VDET0_BIT       = 5;
    localparam int          VDET1_BIT       = 6;
    localparam int          VDET2_BIT       = 7;
    localparam int          XSTOP_BIT       = 0;
    localparam int          PINSEL_BIT      = 1;
    localparam int          FBOFF_BIT       = 2;
    localparam int          SRCSEL_BIT      = 3;
    localparam int          STOPREQ_BIT     = 4;
    // Reset values and boot option sample count
    localparam logic        XSTOP_RST       = 1'b1;
    localparam logic        SRCSEL_RST      = 1'b1;
    localparam logic [1:0]  BOOT_SAMPLE_CYC = 2'h2;
endpackage : clk_src_pkg

/* src/vdet_enable_delay.sv */
// Enable delay timer for one voltage detection circuit
`timescale 1ns/1ps
module vdet_enable_delay #(
    parameter int DELAY_CYC = clk_src_pkg::VDET_DELAY_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,
    output logic      active
);
    import clk_src_pkg::*;
    localparam int CNT_W = $clog2(DELAY_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_CYC - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             active;
    } dly_state_t;

    dly_state_t st_q;
    dly_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (!enable) begin
            st_d = '0;
        end else if (!st_q.active) begin
            if (st_q.cnt == CNT_LAST) begin
                st_d.active = 1'b1; // RQ13 RQ14
            end else begin
                st_d.cnt = st_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign active = st_q.active;

    delay_early_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13 RQ14
        $rose(st_q.active) |-> $past(st_q.cnt) == CNT_LAST && $past(enable))
        else $error("detector active before enable delay");
    delay_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13 RQ14
        !enable |=> !st_q.active)
        else $error("detector active while disabled");
endmodule : vdet_enable_delay

/* src/clock_source_control.sv */
// Clock source control: trims, voltage-detect enables, crystal control, APB slave
//////////////////////////////////////////////////////////////////////////////////
// How it works
// RQ1 - Writing 1 to prescaler reset bit 7 restarts prescaler; it reads 0.
// RQ2 - First factory register holds the 36.864 MHz trim for trim A.
// RQ3 - Second factory register holds the 36.864 MHz trim for trim B.
// RQ4 - Third and fourth factory registers hold the 32 MHz trims A and B.
// RQ5 - Both trim registers reset to factory values giving 40 MHz.
// RQ6 - Trim B accepts writes only while the clock unlock bit is 1.
// RQ7 - Software rewrites trim B only while the fast oscillator is off.
// RQ8 - Detector 0 enable resets to inverse of the boot option; others 0.
// RQ9 - Bits 5, 6, 7 enable voltage detectors 0, 1, 2.
// RQ10 - Bit 0 enables internal low power; bits 1 to 4 reserved.
// RQ11 - Low power bit only around wait mode; no stop mode while set.
// RQ12 - Software writes detector 0 enable with its reset value only.
// RQ13 - Detector 1 operates only after the enable delay from its rise.
// RQ14 - Detector 2 operates only after the enable delay from its rise.
// RQ15 - Voltage-detect register accepts writes only while voltage unlock is 1.
// RQ16 - Crystal oscillator is stopped during and after reset.
// RQ17 - With pin select 1, clearing crystal stop starts the crystal.
// RQ18 - Crystal clock is the CPU source when source select is 0.
// RQ19 - Software sets crystal stop only while on-chip clock is selected.
// RQ20 - External clock on crystal out pin ignores the crystal stop bit.
// RQ21 - Stop mode stops all clocks and disconnects the feedback resistor; here it gates only the crystal outputs, not fast_osc_on.
// RQ22 - Feedback resistor off bit set to 1 disconnects the resistor.
// RQ23 - Fast oscillator control bit 0 turns the fast oscillator on.
// RQ24 - Prescaler reset is a one-cycle pulse with no stored flag.
`timescale 1ns/1ps
module clock_source_control #(
    parameter logic [7:0] TRIM_A_40M  = 8'h80,
    parameter logic [7:0] TRIM_B_40M  = 8'h80,
    parameter logic [7:0] TRIM_A_36M  = 8'h70,
    parameter logic [7:0] TRIM_B_36M  = 8'h70,
    parameter logic [7:0] TRIM_A_32M  = 8'h60,
    parameter logic [7:0] TRIM_B_32M  = 8'h60,
    parameter int         VDET_DELAY  = clk_src_pkg::VDET_DELAY_CYC
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [clk_src_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [31:0]                        prdata,
    input  wire logic                          boot_vdet0_select,
    input  wire logic                          ext_clock_present,
    input  wire logic                          wake_event,
    output logic                               prescaler_reset_pulse,
    output logic                               fast_osc_on,
    output logic [7:0]                         fast_osc_trim_a,
    output logic [7:0]                         fast_osc_trim_b,
    output logic                               internal_low_power_en,
    output logic                               vdet0_en,
    output logic                               vdet1_en,
    output logic                               vdet2_en,
    output logic                               vdet1_active,
    output logic                               vdet2_active,
    output logic                               crystal_drive_en,
    output logic                               crystal_clock_run,
    output logic                               feedback_resistor_on,
    output logic                               crystal_clock_selected,
    output logic                               stop_mode_active
);
    import clk_src_pkg::*;

    typedef struct packed {
        logic        wake_s1;
        logic        wake_s2;
        logic        strap_s1;
        logic        strap_s2;
        logic        ext_s1;
        logic        ext_s2;
        logic [1:0]  boot_cnt;
        logic        boot_done;
        logic        unlock_clk;
        logic        unlock_volt;
        logic        fast_on;
        logic [7:0]  trim_a;
        logic [7:0]  trim_b;
        logic        low_power;
        logic        vdet0;
        logic        vdet1;
        logic        vdet2;
        logic        pin_sel;
        logic        xtal_stop;
        logic        fb_off;
        logic        src_sel;
        logic        stop_req;
        logic        presc_pulse;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        xtal_drive;
        logic        xtal_run;
        logic        fb_conn;
        logic        xtal_sel;
    } ctl_state_t;

    ctl_state_t       st_q;
    ctl_state_t       st_d;
    logic [IDX_W-1:0] idx;
    logic             aligned;
    logic             hit;
    logic [7:0]       rd_byte;
    logic             access;
    logic             commit;
    logic             wr;
    logic [1:0]       det_en;
    logic [1:0]       det_act;

    //////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign idx     = paddr[IDX_W+1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign access  = psel && penable && !st_q.pready;
    assign commit  = psel && penable && st_q.pready;
    assign wr      = commit && pwrite && hit;

    always_comb begin
        hit     = aligned;
        rd_byte = 8'h00;
        case (idx)
            IDX_CLK_MODE: begin
                rd_byte[XSTOP_BIT]   = st_q.xtal_stop;
                rd_byte[PINSEL_BIT]  = st_q.pin_sel;
                rd_byte[FBOFF_BIT]   = st_q.fb_off;
                rd_byte[SRCSEL_BIT]  = st_q.src_sel;
                rd_byte[STOPREQ_BIT] = st_q.stop_req;
            end
            IDX_WPROT: begin
                rd_byte[UNLOCK_CLK_BIT]  = st_q.unlock_clk;
                rd_byte[UNLOCK_VOLT_BIT] = st_q.unlock_volt;
            end
            IDX_FAST_CTRL: rd_byte[FAST_ON_BIT] = st_q.fast_on;
            IDX_TRIM_A:    rd_byte = st_q.trim_a;
            IDX_PRESC:     rd_byte = 8'h00; // RQ1
            IDX_F36_A:     rd_byte = TRIM_A_36M; // RQ2
            IDX_F36_B:     rd_byte = TRIM_B_36M; // RQ3
            IDX_F32_A:     rd_byte = TRIM_A_32M; // RQ4
            IDX_F32_B:     rd_byte = TRIM_B_32M; // RQ4
            IDX_TRIM_B:    rd_byte = st_q.trim_b;
            IDX_VDET: begin
                rd_byte[LOWPWR_BIT] = st_q.low_power;
                rd_byte[VDET0_BIT]  = st_q.vdet0;
                rd_byte[VDET1_BIT]  = st_q.vdet1;
                rd_byte[VDET2_BIT]  = st_q.vdet2;
            end
            default: hit = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d             = st_q;
        st_d.wake_s1     = wake_event;
        st_d.wake_s2     = st_q.wake_s1;
        st_d.strap_s1    = boot_vdet0_select;
        st_d.strap_s2    = st_q.strap_s1;
        st_d.ext_s1      = ext_clock_present;
        st_d.ext_s2      = st_q.ext_s1;
        st_d.presc_pulse = 1'b0; // RQ24
        // One wait state keeps pready and prdata straight from flops
        st_d.pready      = access;
        st_d.pslverr     = access && !hit;
        st_d.prdata      = access ? {24'h000000, rd_byte} : st_q.prdata;

        // Strap can only be caught after release, so bit 5 loads late
        if (!st_q.boot_done) begin
            if (st_q.boot_cnt == BOOT_SAMPLE_CYC) begin
                st_d.vdet0     = !st_q.strap_s2; // RQ8
                st_d.boot_done = 1'b1;
            end else begin
                st_d.boot_cnt = st_q.boot_cnt + 2'h1;
            end
        end

        if (st_q.wake_s2) begin
            st_d.stop_req = 1'b0;
        end

        if (wr) begin
            case (idx)
                IDX_WPROT: begin
                    st_d.unlock_clk  = pwdata[UNLOCK_CLK_BIT];
                    st_d.unlock_volt = pwdata[UNLOCK_VOLT_BIT];
                end
                IDX_PRESC: begin
                    st_d.presc_pulse = pwdata[PRESC_BIT]; // RQ1 RQ24
                end
                IDX_CLK_MODE: begin
                    if (st_q.unlock_clk) begin
                        st_d.xtal_stop = pwdata[XSTOP_BIT]; // RQ17
                        st_d.pin_sel   = pwdata[PINSEL_BIT];
                        st_d.fb_off    = pwdata[FBOFF_BIT]; // RQ22
                        st_d.src_sel   = pwdata[SRCSEL_BIT]; // RQ18
                        // Software entry beats a wake in the same cycle
                        if (pwdata[STOPREQ_BIT]) begin
                            st_d.stop_req = 1'b1;
                        end
                    end
                end
                IDX_FAST_CTRL: begin
                    if (st_q.unlock_clk) begin
                        st_d.fast_on = pwdata[FAST_ON_BIT]; // RQ23
                    end
                end
                IDX_TRIM_A: begin
                    if (st_q.unlock_clk) begin
                        st_d.trim_a = pwdata[7:0];
                    end
                end
                IDX_TRIM_B: begin
                    if (st_q.unlock_clk) begin
                        st_d.trim_b = pwdata[7:0]; // RQ6
                    end
                end
                IDX_VDET: begin
                    if (st_q.unlock_volt) begin // RQ15
                        st_d.low_power = pwdata[LOWPWR_BIT]; // RQ10
                        st_d.vdet0     = pwdata[VDET0_BIT]; // RQ9
                        st_d.vdet1     = pwdata[VDET1_BIT]; // RQ9
                        st_d.vdet2     = pwdata[VDET2_BIT]; // RQ9
                    end
                end
                default: st_d.pslverr = st_q.pslverr;
            endcase
        end

        // Crystal outputs follow the next state so they line up with it
        st_d.xtal_drive = st_d.pin_sel && !st_d.xtal_stop && !st_d.stop_req; // RQ16 RQ17 RQ21
        // An external clock cannot be stopped here, only gated in stop mode or while pin select is 0
        st_d.xtal_run   = (st_d.xtal_drive || (st_q.ext_s2 && st_d.pin_sel))
                          && !st_d.stop_req; // RQ20 RQ21
        st_d.fb_conn    = st_d.pin_sel && !st_d.fb_off && !st_d.stop_req; // RQ21 RQ22
        // Own flop so the select output carries no inverter after the register
        st_d.xtal_sel   = !st_d.src_sel; // RQ18
    end

    //////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q           <= '0;
            st_q.trim_a    <= TRIM_A_40M; // RQ5
            st_q.trim_b    <= TRIM_B_40M; // RQ5
            st_q.xtal_stop <= XSTOP_RST; // RQ16
            st_q.src_sel   <= SRCSEL_RST;
            st_q.xtal_sel  <= !SRCSEL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Detector enable delays

    assign det_en = {st_q.vdet2, st_q.vdet1};

    for (genvar i = 0; i < 2; i++) begin : g_det
        vdet_enable_delay #(
            .DELAY_CYC (VDET_DELAY)
        ) u_delay (
            .pclk    (pclk),
            .presetn (presetn),
            .enable  (det_en[i]),
            .active  (det_act[i])
        );
    end

    assign vdet1_active           = det_act[0];
    assign vdet2_active           = det_act[1];
    assign pready                 = st_q.pready;
    assign pslverr                = st_q.pslverr;
    assign prdata                 = st_q.prdata;
    assign prescaler_reset_pulse  = st_q.presc_pulse;
    assign fast_osc_on            = st_q.fast_on;
    assign fast_osc_trim_a        = st_q.trim_a;
    assign fast_osc_trim_b        = st_q.trim_b;
    assign internal_low_power_en  = st_q.low_power;
    assign vdet0_en               = st_q.vdet0;
    assign vdet1_en               = st_q.vdet1;
    assign vdet2_en               = st_q.vdet2;
    assign crystal_drive_en       = st_q.xtal_drive;
    assign crystal_clock_run      = st_q.xtal_run;
    assign feedback_resistor_on   = st_q.fb_conn;
    assign crystal_clock_selected = st_q.xtal_sel; // RQ18
    assign stop_mode_active       = st_q.stop_req;

    //////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence presc_write_s;
        wr && idx == IDX_PRESC && pwdata[PRESC_BIT];
    endsequence

    sequence one_pulse_s;
        st_q.presc_pulse ##1 !st_q.presc_pulse;
    endsequence

    presc_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1 RQ24
        presc_write_s |=> one_pulse_s)
        else $error("prescaler reset pulse not one cycle");
    presc_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ24
        st_q.presc_pulse |-> $past(wr) && $past(idx) == IDX_PRESC)
        else $error("prescaler pulse without write");
    presc_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        commit && !pwrite && idx == IDX_PRESC |-> prdata == 32'h00000000)
        else $error("prescaler reset register read nonzero");
    factory_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3 only
        commit && !pwrite && idx == IDX_F36_B && aligned |-> prdata[7:0] == TRIM_B_36M)
        else $error("factory trim value wrong");
    trim_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        wr && idx == IDX_TRIM_B && !st_q.unlock_clk |=> $stable(st_q.trim_b))
        else $error("trim B written while locked");
    trim_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        wr && idx == IDX_TRIM_B && st_q.unlock_clk |=> st_q.trim_b == $past(pwdata[7:0]))
        else $error("trim B unlocked write lost");
    vdet_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        wr && idx == IDX_VDET && !st_q.unlock_volt
        |=> $stable({st_q.vdet2, st_q.vdet1, st_q.low_power}))
        else $error("voltage register written while locked");
    boot_vdet0_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        $rose(st_q.boot_done) |-> st_q.vdet0 == !$past(st_q.strap_s2))
        else $error("detector 0 boot value wrong");
    xtal_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        !st_q.boot_done |-> !crystal_drive_en && !crystal_clock_run)
        else $error("crystal running after reset");
    xtal_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
        st_q.pin_sel && !st_q.xtal_stop && !st_q.stop_req |-> crystal_drive_en)
        else $error("crystal not started");
    ext_clock_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        st_q.ext_s2 && st_d.pin_sel && !st_d.stop_req |=> crystal_clock_run)
        else $error("external clock stopped by stop bit");
    stop_all_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
        st_q.stop_req |-> !crystal_clock_run && !feedback_resistor_on)
        else $error("clock runs in stop mode");
    fb_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
        st_q.fb_off |-> !feedback_resistor_on)
        else $error("feedback resistor still connected");
endmodule : clock_source_control

/* verif/crystal_source_model.sv */
// Behavioural model of the external clock source on the crystal pins
`timescale 1ns/1ps
module crystal_source_model (
    input  wire logic pclk,
    input  wire logic feed_ext,
    output logic      ext_clock_present
);
    // Outside circuit alone starts or stops the fed clock
    initial begin
        ext_clock_present = 1'b0;
        forever @(posedge pclk) ext_clock_present <= feed_ext;
    end
endmodule : crystal_source_model

/* verif/testbench.sv */
// Self-checking testbench for the clock source control block
`timescale 1ns/1ps
module testbench;
    import clk_src_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic       err;
    } row_t;
    // Factory values are arbitrary; distinct so a swapped register shows
    localparam logic [7:0] A40 = 8'h81;
    localparam logic [7:0] B40 = 8'h82;
    localparam logic [7:0] A36 = 8'h71;
    localparam logic [7:0] B36 = 8'h72;
    localparam logic [7:0] A32 = 8'h61;
    localparam logic [7:0] B32 = 8'h62;
    localparam int         VD  = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, fast_osc_trim_a, fast_osc_trim_b;
    logic [31:0] pwdata, prdata;
    logic        boot_vdet0_select, ext_clock_present, wake_event, feed_ext;
    logic        prescaler_reset_pulse, fast_osc_on, internal_low_power_en;
    logic        vdet0_en, vdet1_en, vdet2_en, vdet1_active, vdet2_active;
    logic        crystal_drive_en, crystal_clock_run, feedback_resistor_on;
    logic        crystal_clock_selected, stop_mode_active;
    logic [8:0]  obs;
    int          failures, n_checks;
    assign obs = {stop_mode_active, crystal_clock_selected, feedback_resistor_on,
                  crystal_clock_run, crystal_drive_en, vdet2_en, vdet1_en, vdet0_en,
                  internal_low_power_en};
    row_t rows [0:19] = '{
        '{1'b0, IDX_VDET, 8'h00, 8'h20, 1'b0},
        '{1'b1, IDX_VDET, 8'hE1, 8'h00, 1'b0},
        '{1'b0, IDX_VDET, 8'h00, 8'h20, 1'b0},
        '{1'b0, IDX_F36_A, 8'h00, A36, 1'b0},
        '{1'b0, IDX_F36_B, 8'h00, B36, 1'b0},
        '{1'b0, IDX_F32_A, 8'h00, A32, 1'b0},
        '{1'b0, IDX_F32_B, 8'h00, B32, 1'b0},
        '{1'b0, IDX_TRIM_A, 8'h00, A40, 1'b0},
        '{1'b0, IDX_TRIM_B, 8'h00, B40, 1'b0},
        '{1'b1, IDX_TRIM_B, 8'h33, 8'h00, 1'b0},
        '{1'b0, IDX_TRIM_B, 8'h00, B40, 1'b0},
        '{1'b1, IDX_WPROT, 8'h09, 8'h00, 1'b0},
        '{1'b1, IDX_TRIM_B, 8'h33, 8'h00, 1'b0},
        '{1'b0, IDX_TRIM_B, 8'h00, 8'h33, 1'b0},
        '{1'b1, IDX_F36_A, 8'hFF, 8'h00, 1'b0},
        '{1'b0, IDX_F36_A, 8'h00, A36, 1'b0},
        '{1'b1, IDX_VDET, 8'hE1, 8'h00, 1'b0},
        '{1'b1, IDX_PRESC, 8'h80, 8'h00, 1'b0},
        '{1'b0, IDX_PRESC, 8'h00, 8'h00, 1'b0},
        '{1'b0, 6'h3F, 8'h00, 8'h00, 1'b1}
    };
    clock_source_control #(.TRIM_A_40M(A40), .TRIM_B_40M(B40), .TRIM_A_36M(A36),
        .TRIM_B_36M(B36), .TRIM_A_32M(A32), .TRIM_B_32M(B32), .VDET_DELAY(VD)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .boot_vdet0_select(boot_vdet0_select),
        .ext_clock_present(ext_clock_present), .wake_event(wake_event),
        .prescaler_reset_pulse(prescaler_reset_pulse), .fast_osc_on(fast_osc_on),
        .fast_osc_trim_a(fast_osc_trim_a), .fast_osc_trim_b(fast_osc_trim_b),
        .internal_low_power_en(internal_low_power_en), .vdet0_en(vdet0_en),
        .vdet1_en(vdet1_en), .vdet2_en(vdet2_en), .vdet1_active(vdet1_active),
        .vdet2_active(vdet2_active), .crystal_drive_en(crystal_drive_en),
        .crystal_clock_run(crystal_clock_run), .feedback_resistor_on(feedback_resistor_on),
        .crystal_clock_selected(crystal_clock_selected), .stop_mode_active(stop_mode_active));
    crystal_source_model partner (.pclk(pclk), .feed_ext(feed_ext),
        .ext_clock_present(ext_clock_present));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // Request stands until pready is sampled high; data taken at that same edge
    task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= {idx, 2'b00}; pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : acc
    task automatic mode(input logic [7:0] wd, input logic [4:0] exp);
        logic [31:0] rd;
        logic        err;
        acc(1'b1, IDX_CLK_MODE, wd, rd, err);
        repeat (5) @(negedge pclk);
        check(32'(obs[8:4]), 32'(exp));
    endtask : mode
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #(100 * 20000);
        failures++;
        complete_run();
    end
    initial begin
        logic [31:0] rd;
        logic        err;
        int          k;
        int          late;
        failures = 0; n_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; boot_vdet0_select = 1'b0;
        wake_event = 1'b0; feed_ext = 1'b0;
        repeat (8) @(negedge pclk);
        check({16'h0000, fast_osc_trim_a, fast_osc_trim_b}, {16'h0000, A40, B40});
        check(32'(obs), 32'h0);
        repeat (9) @(posedge pclk);
        presetn <= 1'b1;
        // Boot option load lands on the third edge; keep clear of it
        repeat (6) @(posedge pclk);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].idx, rows[i].wd, rd, err);
            check(32'(err), 32'(rows[i].err));
            if (!rows[i].wr && !rows[i].err) check(rd, {24'h0, rows[i].rd});
        end
        check(32'(obs[3:0]), 32'hF);
        $display("test table done");
        for (int j = 0; j < 2; j++) begin
            acc(1'b1, IDX_PRESC, j ? 8'h7F : 8'h80, rd, err);
            k = 0;
            repeat (4) begin
                @(negedge pclk);
                if (prescaler_reset_pulse === 1'b1) k++;
            end
            check(32'(k), j ? 32'h0 : 32'h1);
        end
        $display("test prescaler done");
        acc(1'b1, IDX_VDET, 8'h20, rd, err);
        repeat (2) @(negedge pclk);
        check(32'({obs[3:0], vdet1_active, vdet2_active}), 32'h08);
        acc(1'b1, IDX_VDET, 8'hE0, rd, err);
        k = 0;
        late = 0;
        while (vdet1_active !== 1'b1 && k < 20) begin
            @(negedge pclk);
            k++;
            if (vdet2_active !== vdet1_active) late++;
        end
        check(32'(k), 32'(VD + 1));
        check(32'(late), 32'h0);
        $display("test detector delay done");
        acc(1'b1, IDX_FAST_CTRL, 8'h01, rd, err);
        @(negedge pclk);
        check({23'h0, fast_osc_on, fast_osc_trim_b}, 32'h133);
        mode(8'h0B, 5'b00100);
        mode(8'h0A, 5'b00111);
        mode(8'h02, 5'b01111);
        mode(8'h0A, 5'b00111);
        mode(8'h0F, 5'b00000);
        @(posedge pclk);
        feed_ext <= 1'b1;
        mode(8'h0F, 5'b00010);
        mode(8'h1F, 5'b10000);
        @(posedge pclk);
        wake_event <= 1'b1;
        repeat (2) @(posedge pclk);
        wake_event <= 1'b0;
        repeat (5) @(negedge pclk);
        check(32'(obs[8:4]), 32'h02);
        $display("test crystal done");
        @(posedge pclk);
        presetn <= 1'b0;
        boot_vdet0_select <= 1'b1;
        repeat (3) @(negedge pclk);
        check({15'h0, crystal_clock_run, fast_osc_trim_a, fast_osc_trim_b}, {16'h0, A40, B40});
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(negedge pclk);
        check(32'({crystal_drive_en, vdet0_en}), 32'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule : testbench
